// ---- shared/cssc_defs.svh ----
// Offsets, field positions, reset values and timing counts of the set-point slew control.
`ifndef CSSC_DEFS_SVH
`define CSSC_DEFS_SVH

`define CSSC_CLK_MHZ            50
`define CSSC_IDX_BB_VOLT        6'h19
`define CSSC_IDX_SLEW           6'h1a
`define CSSC_IDX_FIRST_SET      6'h30
`define CSSC_IDX_SECOND_SET     6'h31
`define CSSC_IDX_STATUS         6'h32
`define CSSC_IDX_FIRST_NOW      6'h33
`define CSSC_IDX_SECOND_NOW     6'h34
`define CSSC_RST_BB_VOLT        8'hb2
`define CSSC_RST_SLEW           8'h06
`define CSSC_RST_BB_MV          12'hce4
`define CSSC_BB_PS_BIT          7
`define CSSC_SLEW_GO_BIT        7
`define CSSC_SLEW_AUTO_BIT      6
`define CSSC_SLEW_IMMEDIATE     3'h7
`define CSSC_BB_CODE_KNEE       6'h10
`define CSSC_BB_CODE_LAST       6'h34
`define CSSC_BB_MV_BASE         1175
`define CSSC_BB_MV_FINE         25
`define CSSC_BB_MV_KNEE         1600
`define CSSC_BB_MV_COARSE       50
`define CSSC_STEP_BASE_US       160
`define CSSC_BLANK_MS           5
`define CSSC_STEP_BASE_CYCLES   (`CSSC_STEP_BASE_US * `CSSC_CLK_MHZ)
`define CSSC_BLANK_CYCLES       (`CSSC_BLANK_MS * 1000 * `CSSC_CLK_MHZ)
`define CSSC_RSP_OKAY           2'h0
`define CSSC_RSP_DECODEERROR    2'h3

`endif

// ---- shared/cssc_pkg.sv ----
// Types shared by the set-point slew control modules.
package cssc_pkg;

  typedef logic [5:0]  cssc_code_t;
  typedef logic [17:0] cssc_blank_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } cssc_avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic [1:0]  response;
    logic        waitrequest;
  } cssc_avs_rsp_s;

  typedef struct packed {
    logic        pulse_skip_enable;
    cssc_code_t  code;
    logic [11:0] millivolt;
    logic        monitor_blank;
  } cssc_bb_out_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] readdata;
    logic [1:0]  response;
    logic        go;
    logic        auto_apply_select;
    logic [2:0]  slew_code;
    logic        bb_pulse_skip;
    cssc_code_t  bb_code;
    logic [11:0] bb_mv;
    cssc_code_t  first_target;
    cssc_code_t  second_target;
    cssc_blank_t blank_cnt;
  } cssc_ctrl_s;

endpackage

// ---- core/cssc_step_timer.sv ----
// Step interval tick generator for the slewed buck transitions.
`timescale 1ns/1ps
`include "cssc_defs.svh"
module cssc_step_timer #(
  parameter int BASE_CYCLES = `CSSC_STEP_BASE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] slew_code,
  input  wire logic       restart,
  output logic            tick
);
  localparam int W = $clog2(BASE_CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cssc_timer_s;

  cssc_timer_s st;
  cssc_timer_s next_st;
  logic [W-1:0] limit;

  initial begin
    if (BASE_CYCLES < 64) begin
      $error("BASE_CYCLES must allow six halvings");
    end
  end

  always_comb begin
    next_st = st;
    limit = W'((BASE_CYCLES >> slew_code) - 1);
    tick = 1'b0;
    if (restart) begin
      next_st.cnt = '0;
    end else if (st.cnt >= limit) begin
      tick = 1'b1;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // cssc_step_timer

// ---- core/cssc_stepper.sv ----
// One buck converter's present voltage code, walked toward its target.
`timescale 1ns/1ps
module cssc_stepper #(
  parameter logic [5:0] RESET_CODE = 6'h00
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [5:0] target,
  input  wire logic       immediate,
  input  wire logic       tick,
  output logic [5:0]      present,
  output logic            busy
);
  typedef struct packed {
    logic [5:0] present;
    logic [5:0] goal;
  } cssc_step_s;

  cssc_step_s st;
  cssc_step_s next_st;

  always_comb begin
    next_st = st;
    if (start) begin
      next_st.goal = target;
      if (immediate) begin
        next_st.present = target;
      end
    end else if (immediate) begin
      next_st.present = st.goal;
    end else if (tick && st.present != st.goal) begin
      if (st.present < st.goal) begin
        next_st.present = st.present + 6'h01;
      end else begin
        next_st.present = st.present - 6'h01;
      end
    end
  end

  assign present = st.present;
  assign busy = (st.present != st.goal);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.present <= RESET_CODE;
      st.goal <= RESET_CODE;
    end else begin
      st <= next_st;
    end
  end
endmodule // cssc_stepper

// ---- core/cssc_top.sv ----
// Register slave and set-point control for the buck-boost and slewed buck converters.
`timescale 1ns/1ps
`include "cssc_defs.svh"
module cssc_top #(
  parameter int         STEP_BASE_CYCLES = `CSSC_STEP_BASE_CYCLES,
  parameter int         BLANK_CYCLES     = `CSSC_BLANK_CYCLES,
  parameter logic [5:0] BUCK_RESET_CODE  = 6'h00
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire cssc_pkg::cssc_avs_req_s avs_req,
  output cssc_pkg::cssc_avs_rsp_s      avs_rsp,
  output cssc_pkg::cssc_bb_out_s       bb_out,
  output logic [5:0]                   first_buck_code,
  output logic [5:0]                   second_buck_code,
  output logic                         transition_busy
);

  localparam logic [7:0] RST_SLEW = `CSSC_RST_SLEW;
  localparam logic [7:0] RST_BB   = `CSSC_RST_BB_VOLT;

  cssc_pkg::cssc_ctrl_s st;
  cssc_pkg::cssc_ctrl_s next_st;

  logic       access;
  logic       fire;
  logic [5:0] idx;
  logic       wr_lane;
  logic       wr_bb;
  logic       wr_slew;
  logic       wr_first;
  logic       wr_second;
  logic       go_set;
  logic       auto_start;
  logic       start;
  logic       immediate;
  logic       tick;
  logic       first_busy;
  logic       second_busy;
  logic [5:0] first_now;
  logic [5:0] second_now;
  logic       bb_reserved;

  initial begin
    if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << 18)) begin
      $error("BLANK_CYCLES does not fit the blanking counter");
    end
  end

  // Buck-boost output voltage in millivolts; zero for a reserved code.
  function automatic logic [11:0] bb_millivolt(input logic [5:0] code);
    int mv;
    mv = 0;
    if (code < `CSSC_BB_CODE_KNEE) begin
      mv = `CSSC_BB_MV_BASE + `CSSC_BB_MV_FINE * int'(code);
    end else if (code <= `CSSC_BB_CODE_LAST) begin
      mv = `CSSC_BB_MV_KNEE + `CSSC_BB_MV_COARSE * int'(code - `CSSC_BB_CODE_KNEE);
    end
    return mv[11:0];
  endfunction

  // Decides whether a word index falls on a mapped register.
  function automatic logic index_mapped(input logic [5:0] index);
    logic hit;
    hit = 1'b0;
    case (index)
      `CSSC_IDX_BB_VOLT,
      `CSSC_IDX_SLEW,
      `CSSC_IDX_FIRST_SET,
      `CSSC_IDX_SECOND_SET,
      `CSSC_IDX_STATUS,
      `CSSC_IDX_FIRST_NOW,
      `CSSC_IDX_SECOND_NOW: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  always_comb begin
    next_st = st;
    access = avs_req.read | avs_req.write;
    fire = access & st.ack;
    idx = avs_req.address[7:2];
    wr_lane = fire & avs_req.write & avs_req.byteenable[0];
    wr_bb = wr_lane && (idx == `CSSC_IDX_BB_VOLT);
    wr_slew = wr_lane && (idx == `CSSC_IDX_SLEW);
    wr_first = wr_lane && (idx == `CSSC_IDX_FIRST_SET);
    wr_second = wr_lane && (idx == `CSSC_IDX_SECOND_SET);
    bb_reserved = (st.bb_code > `CSSC_BB_CODE_LAST);

    // The first cycle of a request captures read data; the second completes it.
    next_st.ack = access & ~st.ack;
    if (access && !st.ack) begin
      next_st.readdata = 32'h0000_0000;
      next_st.response = index_mapped(idx) ? `CSSC_RSP_OKAY : `CSSC_RSP_DECODEERROR;
      case (idx)
        `CSSC_IDX_BB_VOLT: begin
          next_st.readdata[7:0] = {st.bb_pulse_skip, 1'b0, st.bb_code};
        end
        `CSSC_IDX_SLEW: begin
          // reserved bits five to three read zero.
          next_st.readdata[7:0] = {st.go, st.auto_apply_select, 3'h0, st.slew_code};
        end
        `CSSC_IDX_FIRST_SET: begin
          next_st.readdata[5:0] = st.first_target;
        end
        `CSSC_IDX_SECOND_SET: begin
          next_st.readdata[5:0] = st.second_target;
        end
        `CSSC_IDX_STATUS: begin
          next_st.readdata[3:0] = {bb_reserved, bb_out.monitor_blank,
                                   second_busy, first_busy};
        end
        `CSSC_IDX_FIRST_NOW: begin
          next_st.readdata[5:0] = first_now;
        end
        `CSSC_IDX_SECOND_NOW: begin
          next_st.readdata[5:0] = second_now;
        end
        default: begin
          next_st.readdata = 32'h0000_0000;
        end
      endcase
    end

    if (wr_bb) begin
      next_st.bb_pulse_skip = avs_req.writedata[`CSSC_BB_PS_BIT];
      next_st.bb_code = avs_req.writedata[5:0];
    end
    next_st.bb_mv = bb_millivolt(next_st.bb_code);

    if (wr_bb) begin
      next_st.blank_cnt = cssc_pkg::cssc_blank_t'(BLANK_CYCLES);
    end else if (st.blank_cnt != '0) begin
      next_st.blank_cnt = st.blank_cnt - 18'h00001;
    end

    if (wr_slew) begin
      next_st.auto_apply_select = avs_req.writedata[`CSSC_SLEW_AUTO_BIT];
      next_st.slew_code = avs_req.writedata[2:0];
    end
    if (wr_first) begin
      next_st.first_target = avs_req.writedata[5:0];
    end
    if (wr_second) begin
      next_st.second_target = avs_req.writedata[5:0];
    end

    go_set = wr_slew & avs_req.writedata[`CSSC_SLEW_GO_BIT];
    auto_start = st.auto_apply_select & (wr_first | wr_second);
    start = go_set | auto_start;

    if (go_set) begin
      next_st.go = 1'b1;
    end else if (st.go && !first_busy && !second_busy) begin
      next_st.go = 1'b0;
    end
  end

  // live slew code for all starts.
  assign immediate = (next_st.slew_code == `CSSC_SLEW_IMMEDIATE);

  cssc_step_timer #(
    .BASE_CYCLES (STEP_BASE_CYCLES)
  ) u_timer (
    .clock     (clock),
    .rst_n     (rst_n),
    .slew_code (st.slew_code),
    .restart   (start),
    .tick      (tick)
  );

  cssc_stepper #(
    .RESET_CODE (BUCK_RESET_CODE)
  ) u_first (
    .clock     (clock),
    .rst_n     (rst_n),
    .start     (start),
    .target    (next_st.first_target),
    .immediate (immediate),
    .tick      (tick),
    .present   (first_now),
    .busy      (first_busy)
  );

  cssc_stepper #(
    .RESET_CODE (BUCK_RESET_CODE)
  ) u_second (
    .clock     (clock),
    .rst_n     (rst_n),
    .start     (start),
    .target    (next_st.second_target),
    .immediate (immediate),
    .tick      (tick),
    .present   (second_now),
    .busy      (second_busy)
  );

  assign avs_rsp.readdata = st.readdata;
  assign avs_rsp.response = st.response;
  assign avs_rsp.waitrequest = access & ~st.ack;

  assign bb_out.pulse_skip_enable = st.bb_pulse_skip;
  assign bb_out.code = st.bb_code;
  assign bb_out.millivolt = st.bb_mv;
  assign bb_out.monitor_blank = (st.blank_cnt != '0);

  assign first_buck_code = first_now;
  assign second_buck_code = second_now;
  assign transition_busy = first_busy | second_busy;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.ack <= 1'b0;
      st.readdata <= 32'h0000_0000;
      st.response <= `CSSC_RSP_OKAY;
      st.go <= RST_SLEW[`CSSC_SLEW_GO_BIT];
      st.auto_apply_select <= RST_SLEW[`CSSC_SLEW_AUTO_BIT];
      st.slew_code <= RST_SLEW[2:0];
      st.bb_pulse_skip <= RST_BB[`CSSC_BB_PS_BIT];
      st.bb_code <= RST_BB[5:0];
      st.bb_mv <= `CSSC_RST_BB_MV;
      st.first_target <= BUCK_RESET_CODE;
      st.second_target <= BUCK_RESET_CODE;
      st.blank_cnt <= 18'h00000;
    end else begin
      st <= next_st;
    end
  end

endmodule // cssc_top

// ---- bench/cssc_top_properties.sv ----
// Concurrent checks on the ports of the set-point slew control.
`timescale 1ns/1ps
module cssc_top_properties #(
  parameter int BLANK_CYCLES = 20
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire cssc_pkg::cssc_avs_req_s avs_req,
  input wire cssc_pkg::cssc_avs_rsp_s avs_rsp,
  input wire cssc_pkg::cssc_bb_out_s  bb_out,
  input wire logic [5:0]              first_buck_code,
  input wire logic [5:0]              second_buck_code,
  input wire logic                    transition_busy
);
  logic       done;
  logic       rd_end;
  logic       wr_bb;
  logic       wr_sl;
  logic [2:0] slew;
  int         since;

  assign done = (avs_req.read | avs_req.write) & ~avs_rsp.waitrequest;
  assign rd_end = done & avs_req.read;
  assign wr_bb = done & avs_req.write & avs_req.byteenable[0] & avs_req.address[7:2] == 6'h19;
  assign wr_sl = done & avs_req.write & avs_req.byteenable[0] & avs_req.address[7:2] == 6'h1a;

  // Shadow of the slew code and cycles since the last buck-boost write.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slew <= 3'h6;
      since <= BLANK_CYCLES;
    end else begin
      if (wr_sl) begin
        slew <= avs_req.writedata[2:0];
      end
      since <= wr_bb ? 0 : (since < BLANK_CYCLES ? since + 1 : since);
    end
  end

  function automatic int mv(input logic [5:0] c);
    return c > 6'h34 ? 0 : (c < 6'h10 ? 1175 + 25 * c : 1600 + 50 * (c - 16));
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_wait;
    (avs_req.read | avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not one cycle");
  property p_hold;
    !wr_bb |=> $stable(bb_out.pulse_skip_enable) && $stable(bb_out.code);
  endproperty
  a_hold: assert property (p_hold) else $error("bb field moved");
  property p_mv;
    int'(bb_out.millivolt) == mv(bb_out.code);
  endproperty
  a_mv: assert property (p_mv) else $error("bb millivolt wrong");
  property p_blank;
    bb_out.monitor_blank == (since < BLANK_CYCLES);
  endproperty
  a_blank: assert property (p_blank) else $error("blank window wrong");
  property p_step;
    slew != 3'h7 && !wr_sl |=>
      6'(first_buck_code - $past(first_buck_code)) inside {6'h00, 6'h01, 6'h3f};
  endproperty
  a_step: assert property (p_step) else $error("step above one code");
  property p_imm;
    slew == 3'h7 && $past(slew) == 3'h7 |-> !transition_busy;
  endproperty
  a_imm: assert property (p_imm) else $error("code seven ramped");
  property p_unmap;
    rd_end && !(avs_req.address[7:2] inside {6'h19, 6'h1a, [6'h30:6'h34]})
      |-> avs_rsp.response == 2'h3 && avs_rsp.readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  property p_bbrd;
    rd_end && avs_req.address[7:2] == 6'h19 |-> avs_rsp.response == 2'h0 &&
      avs_rsp.readdata == {24'h0, bb_out.pulse_skip_enable, 1'b0, bb_out.code};
  endproperty
  a_bbrd: assert property (p_bbrd) else $error("bb readback wrong");

  c_imm: cover property (slew == 3'h7 && $past(slew) == 3'h7);
  c_blank: cover property ($fell(bb_out.monitor_blank));
  c_ramp: cover property (transition_busy [*8]);
endmodule // cssc_top_properties

bind cssc_top cssc_top_properties #(.BLANK_CYCLES(BLANK_CYCLES)) u_props (
  .clock(clock), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp),
  .bb_out(bb_out), .first_buck_code(first_buck_code),
  .second_buck_code(second_buck_code), .transition_busy(transition_busy));

// ---- bench/tb_top.sv ----
// Self-checking bench for the set-point slew control.
`timescale 1ns/1ps
module tb_top;
  logic                    clock;
  logic                    rst_n;
  cssc_pkg::cssc_avs_req_s req;
  cssc_pkg::cssc_avs_rsp_s rsp;
  cssc_pkg::cssc_bb_out_s  bb;
  logic [5:0]              c1;
  logic [5:0]              c2;
  logic                    busy;
  logic [31:0]             q;
  logic [3:0]              be;
  int                      num_errors;
  int                      check_count;
  int                      n;
  logic [7:0]              bbw[4] = '{8'h40, 8'h4f, 8'hd0, 8'hf4};
  int                      bbmv[4] = '{1175, 1550, 1600, 3400};

  cssc_top #(.STEP_BASE_CYCLES(64), .BLANK_CYCLES(20)) dut (
    .clock(clock), .rst_n(rst_n), .avs_req(req), .avs_rsp(rsp), .bb_out(bb),
    .first_buck_code(c1), .second_buck_code(c2), .transition_busy(busy));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= {24'h0, d};
    req.byteenable <= be;
    @(posedge clock);
    while (rsp.waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic gap(output int m);
    logic [5:0] o;
    o = c1;
    m = 0;
    do begin
      @(negedge clock);
      m++;
    end while (c1 === o && m < 300);
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    print_verdict;
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    be = 4'hf;
    num_errors = 0;
    check_count = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    acc(0, 8'h68, 0);
    chk(q, 32'h06);
    acc(0, 8'h64, 0);
    chk(q, 32'hb2);
    foreach (bbw[i]) begin
      acc(1, 8'h64, bbw[i]);
      acc(0, 8'h64, 0);
      chk(bb.monitor_blank, 1'b1);
      chk(q, {24'h0, bbw[i] & 8'hbf});
      chk(bb.millivolt, bbmv[i][11:0]);
      chk(bb.pulse_skip_enable, bbw[i][7]);
      acc(0, 8'hc8, 0);
      chk(q, 32'h4);
    end
    repeat (25) @(negedge clock);
    chk(bb.monitor_blank, 1'b0);
    chk(c1, 6'h00);
    acc(0, 8'h04, 0);
    chk(q, 32'h0);
    chk(rsp.response, 2'h3);
    acc(1, 8'h68, 8'h3e);
    be = 4'h0;
    acc(1, 8'h68, 8'h01);
    be = 4'hf;
    acc(0, 8'h68, 0);
    chk(q, 32'h06);
    acc(1, 8'hc0, 8'h05);
    acc(1, 8'hc4, 8'h03);
    repeat (4) @(negedge clock);
    chk(c1, 6'h00);
    acc(1, 8'h68, 8'h86);
    n = 0;
    do begin
      acc(0, 8'h68, 0);
      n++;
    end while (q[7] && n < 20);
    chk(q[7], 1'b0);
    chk(c1, 6'h05);
    chk(c2, 6'h03);
    acc(1, 8'hc0, 8'h0a);
    acc(1, 8'h68, 8'h06);
    repeat (4) @(negedge clock);
    chk(c1, 6'h05);
    acc(1, 8'h68, 8'h87);
    @(negedge clock);
    chk(c1, 6'h0a);
    for (int k = 0; k < 7; k++) begin
      acc(1, 8'hc0, 8'h0b + k[7:0]);
      acc(1, 8'h68, 8'h80 | k[7:0]);
      gap(n);
      chk(n, (64 >> k) + 1);
      chk(busy, 1'b0);
    end
    acc(1, 8'h68, 8'h41);
    acc(1, 8'hc0, 8'h10);
    gap(n);
    chk(n, 33);
    chk(c1, 6'h10);
    acc(1, 8'h68, 8'h47);
    acc(1, 8'hc4, 8'h30);
    @(negedge clock);
    chk(c2, 6'h30);
    acc(1, 8'h68, 8'h46);
    acc(1, 8'hc4, 8'h20);
    repeat (9) @(negedge clock);
    chk(c2, 6'h28);
    repeat (10) @(negedge clock);
    chk(c2, 6'h20);
    acc(0, 8'hd0, 0);
    chk(q, 32'h20);
    acc(0, 8'hcc, 0);
    chk(q, 32'h10);
    acc(0, 8'hc4, 0);
    chk(q, 32'h20);
    acc(0, 8'hc8, 0);
    chk(q, 32'h0);
    acc(0, 8'h68, 0);
    chk(q, 32'h46);
    print_verdict;
  end
endmodule // tb_top
